//--- madi_inserter_pkg.sv
// Package: constants, types and register map for the channel group inserter
package madi_inserter_pkg;
	localparam int unsigned STREAM_CHANNELS  = 64;
	localparam int unsigned AES_INPUTS       = 12;
	localparam int unsigned SAMPLE_BITS      = 24;
	localparam int unsigned CHAN_BITS        = 6;
	localparam int unsigned SAMPLE_RATE_HZ   = 48000;
	localparam int unsigned CLOCK_HZ         = 20000000;
	localparam int unsigned GROUP_LOW_BASE   = 0;
	localparam int unsigned GROUP_MID_BASE   = 24;
	localparam int unsigned GROUP_HIGH_BASE  = 48;
	localparam int unsigned GROUP_WIDE_SIZE  = 24;
	localparam int unsigned GROUP_HIGH_SIZE  = 16;
	// Reference lost after this many missing frame periods
	localparam int unsigned REF_LOSS_PERIODS = 4;
	localparam int unsigned FRAME_CYCLES     = CLOCK_HZ / SAMPLE_RATE_HZ;
	localparam int unsigned REF_TIMEOUT      = FRAME_CYCLES * REF_LOSS_PERIODS;
	localparam int unsigned AES_TIMEOUT      = FRAME_CYCLES * REF_LOSS_PERIODS;
	localparam int unsigned ACCESS_HOLD      = 16'h2000;
	localparam int unsigned TIMER_BITS       = 16;

	// APB register byte addresses
	localparam logic [7:0] ADDR_STATUS    = 8'h00;
	localparam logic [7:0] ADDR_CLEAR     = 8'h04;
	localparam logic [7:0] ADDR_ENABLE    = 8'h08;
	localparam logic [7:0] ADDR_INDICATE  = 8'h0c;
	localparam logic [7:0] ADDR_GROUP     = 8'h10;
	localparam int unsigned EVENT_BITS    = 4;
	localparam int unsigned EV_LOCK_LOST  = 0;
	localparam int unsigned EV_REF_LOST   = 1;
	localparam int unsigned EV_LOCK_GAIN  = 2;
	localparam int unsigned EV_DETECT_CHG = 3;

	typedef enum logic [1:0] {
		group_low_type_v  = 2'b00,
		group_mid_type_v  = 2'b01,
		group_high_type_v = 2'b10,
		group_none_type_v = 2'b11
	} group_type;

	// One channel slot of the multichannel stream
	typedef struct packed {
		logic                   valid;
		logic [CHAN_BITS-1:0]   channel;
		logic [SAMPLE_BITS-1:0] sample;
	} slot_type;

	// One decoded AES3 subframe from the crosspoint
	typedef struct packed {
		logic                   valid;
		logic                   second;
		logic [SAMPLE_BITS-1:0] sample;
	} subframe_type;

	typedef struct packed {
		logic                  lock;
		logic                  reference;
		logic                  access;
		logic                  unused_a;
		logic                  unused_b;
		logic [AES_INPUTS-1:0] detect;
	} indicator_type;
endpackage

//--- madi_channel_group_inserter.sv
// Module: inserts twelve AES3 pairs (eight in the high group) as a channel group into a 64-channel stream
`timescale 1ns/1ns
`default_nettype none
module madi_channel_group_inserter #(
	parameter int unsigned ACCESS_HOLD_CYCLES = madi_inserter_pkg::ACCESS_HOLD
) (
	input  wire  logic                                      pclk,
	input  wire  logic                                      presetn,
	input  wire  logic [7:0]                                paddr,
	input  wire  logic                                      psel,
	input  wire  logic                                      penable,
	input  wire  logic                                      pwrite,
	input  wire  logic [31:0]                               pwdata,
	output var   logic [31:0]                               prdata,
	output var   logic                                      pready,
	output var   logic                                      pslverr,
	input  wire  logic [7:0]                                group_select_switch,
	input  wire  logic                                      digital_audio_reference,
	input  wire  madi_inserter_pkg::slot_type               stream_in,
	input  wire  logic                                      stream_in_locked,
	input  wire  madi_inserter_pkg::subframe_type [11:0]    aes_in,
	output var   madi_inserter_pkg::slot_type               stream_out,
	output var   madi_inserter_pkg::indicator_type          indicators,
	output var   logic                                      irq
);
	import madi_inserter_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Synchronisers for pins from outside the clock domain
	logic [7:0]  switch_meta;
	logic [7:0]  switch_sync;
	logic [2:0]  ref_sync;
	logic [1:0]  lock_sync;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			switch_meta <= 8'hff;
			switch_sync <= 8'hff;
			ref_sync    <= 3'h0;
			lock_sync   <= 2'h0;
		end else begin
			switch_meta <= group_select_switch;
			switch_sync <= switch_meta;
			ref_sync    <= {ref_sync[1:0], digital_audio_reference};
			lock_sync   <= {lock_sync[0], stream_in_locked};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Group decode
	function automatic group_type decode_group(input logic [1:0] sw);
		// Bit 0 is switch 1; low means On
		case (sw)
			2'b00:   decode_group = group_low_type_v;
			2'b01:   decode_group = group_mid_type_v;
			2'b10:   decode_group = group_high_type_v;
			default: decode_group = group_none_type_v;
		endcase
	endfunction

	group_type group;
	assign group = decode_group(switch_sync[1:0]);

	// Channel index into the group; negative or beyond means outside
	function automatic logic in_group(input group_type g, input logic [CHAN_BITS-1:0] ch);
		case (g)
			group_low_type_v:  in_group = ch < CHAN_BITS'(GROUP_LOW_BASE + GROUP_WIDE_SIZE);
			group_mid_type_v:  in_group = ch >= CHAN_BITS'(GROUP_MID_BASE)
				&& ch < CHAN_BITS'(GROUP_MID_BASE + GROUP_WIDE_SIZE);
			group_high_type_v: in_group = ch >= CHAN_BITS'(GROUP_HIGH_BASE);
			default:           in_group = 1'b0;
		endcase
	endfunction

	function automatic logic [CHAN_BITS-1:0] group_base(input group_type g);
		case (g)
			group_mid_type_v:  group_base = CHAN_BITS'(GROUP_MID_BASE);
			group_high_type_v: group_base = CHAN_BITS'(GROUP_HIGH_BASE);
			default:           group_base = CHAN_BITS'(GROUP_LOW_BASE);
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Latest subframe of each AES3 input
	logic [SAMPLE_BITS-1:0] held [AES_INPUTS*2];
	logic [AES_INPUTS-1:0]  frame_seen;

	genvar gi;
	generate
		for (gi = 0; gi < AES_INPUTS; gi++) begin : g_hold
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					held[2*gi]   <= '0;
					held[2*gi+1] <= '0;
				end else if (aes_in[gi].valid) begin
					// Silent samples are stored like any other
					if (aes_in[gi].second)
						held[2*gi+1] <= aes_in[gi].sample;
					else
						held[2*gi] <= aes_in[gi].sample;
				end
			end
			assign frame_seen[gi] = aes_in[gi].valid;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Stream merge, one slot per cycle, one cycle latency
	logic [CHAN_BITS-1:0] offset;
	assign offset = stream_in.channel - group_base(group);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stream_out <= '0;
		end else begin
			stream_out.valid   <= stream_in.valid;
			stream_out.channel <= stream_in.channel;
			if (in_group(group, stream_in.channel))
				stream_out.sample <= held[offset[4:0]];
			else if (group == group_low_type_v)
				stream_out.sample <= '0;
			else
				stream_out.sample <= stream_in.sample;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Signal detect: framed subframes within a timeout, silence included
	logic [TIMER_BITS-1:0] aes_timer [AES_INPUTS];
	logic [AES_INPUTS-1:0] detect;

	generate
		for (gi = 0; gi < AES_INPUTS; gi++) begin : g_detect
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					aes_timer[gi] <= '0;
					detect[gi]    <= 1'b0;
				end else if (frame_seen[gi]) begin
					aes_timer[gi] <= TIMER_BITS'(AES_TIMEOUT);
					detect[gi]    <= 1'b1;
				end else if (aes_timer[gi] != '0) begin
					aes_timer[gi] <= aes_timer[gi] - 1'b1;
				end else begin
					detect[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Reference presence from its edges
	logic [TIMER_BITS-1:0] ref_timer;
	logic                  ref_present;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_timer   <= '0;
			ref_present <= 1'b0;
		end else if (ref_sync[2] != ref_sync[1]) begin
			ref_timer   <= TIMER_BITS'(REF_TIMEOUT);
			ref_present <= 1'b1;
		end else if (ref_timer != '0) begin
			ref_timer <= ref_timer - 1'b1;
		end else begin
			ref_present <= 1'b0;
		end
	end

	logic locked;
	assign locked = lock_sync[1] & ref_present;

	////////////////////////////////////////////////////////////////////////////
	// Access stretch for the indicator
	logic [TIMER_BITS-1:0] access_timer;
	logic                  access_hit;
	assign access_hit = psel & ~penable;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			access_timer <= '0;
		else if (access_hit)
			access_timer <= TIMER_BITS'(ACCESS_HOLD_CYCLES);
		else if (access_timer != '0)
			access_timer <= access_timer - 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			indicators <= '0;
		end else begin
			indicators.lock      <= locked;
			indicators.reference <= ref_present;
			indicators.access    <= access_hit | (access_timer != '0);
			indicators.unused_a  <= 1'b0;
			indicators.unused_b  <= 1'b0;
			indicators.detect    <= detect;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Events, sticky status, enable, interrupt
	logic                  locked_d;
	logic                  ref_d;
	logic [AES_INPUTS-1:0] detect_d;
	logic [EVENT_BITS-1:0] events;
	logic [EVENT_BITS-1:0] status;
	logic [EVENT_BITS-1:0] enable;
	logic                  wr_access;
	logic [EVENT_BITS-1:0] clear_mask;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			locked_d <= 1'b0;
			ref_d    <= 1'b0;
			detect_d <= '0;
		end else begin
			locked_d <= locked;
			ref_d    <= ref_present;
			detect_d <= detect;
		end
	end

	always_comb begin
		events                = '0;
		events[EV_LOCK_LOST]  = locked_d & ~locked;
		events[EV_REF_LOST]   = ref_d & ~ref_present;
		events[EV_LOCK_GAIN]  = ~locked_d & locked;
		events[EV_DETECT_CHG] = detect_d != detect;
	end

	assign wr_access  = psel & penable & pwrite;
	assign clear_mask = (wr_access && paddr == ADDR_CLEAR) ? pwdata[EVENT_BITS-1:0] : '0;

	// Set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			status <= '0;
		else
			status <= (status & ~clear_mask) | events;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			enable <= '0;
		else if (wr_access && paddr == ADDR_ENABLE)
			enable <= pwdata[EVENT_BITS-1:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(((status & ~clear_mask) | events) & enable);
	end

	////////////////////////////////////////////////////////////////////////////
	// APB slave, zero wait states
	function automatic logic mapped(input logic [7:0] a);
		mapped = a == ADDR_STATUS || a == ADDR_CLEAR || a == ADDR_ENABLE
			|| a == ADDR_INDICATE || a == ADDR_GROUP;
	endfunction

	logic [31:0] next_prdata;

	always_comb begin
		next_prdata = '0;
		case (paddr)
			ADDR_STATUS:   next_prdata[EVENT_BITS-1:0] = status;
			ADDR_ENABLE:   next_prdata[EVENT_BITS-1:0] = enable;
			ADDR_INDICATE: next_prdata[$bits(indicator_type)-1:0] = indicators;
			ADDR_GROUP:    next_prdata[1:0] = group;
			default:       next_prdata = '0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			prdata  <= pwrite ? 32'h0 : next_prdata;
			pready  <= 1'b1;
			pslverr <= !mapped(paddr) || (pwrite && paddr == ADDR_STATUS);
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end
endmodule // madi_channel_group_inserter
`default_nettype wire

//--- madi_inserter_monitor.sv
// Checker for the channel group inserter ports
`timescale 1ns/1ns
`default_nettype none
module madi_inserter_monitor (
	input wire logic                           pclk,
	input wire logic                           presetn,
	input wire logic                           psel,
	input wire logic                           penable,
	input wire logic [7:0]                     group_select_switch,
	input wire madi_inserter_pkg::slot_type     stream_in,
	input wire logic                           stream_in_locked,
	input wire madi_inserter_pkg::subframe_type [11:0] aes_in,
	input wire madi_inserter_pkg::slot_type     stream_out,
	input wire madi_inserter_pkg::indicator_type indicators
);
	import madi_inserter_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [1:0] sw_prev;
	logic [2:0] held;
	wire logic [1:0] g = group_select_switch[1:0];
	// Group steady long enough to have passed the synchroniser and the output flop
	wire logic ok = held >= 3'd5 && g == sw_prev && stream_in.valid;
	wire logic [5:0] ch = stream_in.channel;
	// Cycles since the group switch last moved
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_prev <= 2'b11;
			held <= '0;
		end else begin
			sw_prev <= g;
			held <= (g != sw_prev) ? 3'd0 : (held == 3'd7 ? held : held + 3'd1);
		end
	end
	slot_timing_a: assert property (stream_in.valid |=> stream_out.valid
		&& stream_out.channel == $past(stream_in.channel)) else $error("slot lost or late");
	pass_all_a: assert property (ok && g == 2'b11
		|=> stream_out.sample == $past(stream_in.sample)) else $error("pass-through broken");
	low_silent_a: assert property (ok && g == 2'b00 && ch >= 6'd24
		|=> stream_out.sample == '0) else $error("outside channel not silent");
	mid_sides_a: assert property (ok && g == 2'b01 && (ch < 6'd24 || ch >= 6'd48)
		|=> stream_out.sample == $past(stream_in.sample)) else $error("side channel changed");
	high_keep_a: assert property (ok && g == 2'b10 && ch < 6'd48
		|=> stream_out.sample == $past(stream_in.sample)) else $error("low channels changed");
	unused_off_a: assert property (!indicators.unused_a && !indicators.unused_b)
		else $error("unused indicator lit");
	lock_drop_a: assert property (!stream_in_locked [*4] |=> !indicators.lock)
		else $error("lock shown while unlocked");
	access_lit_a: assert property (psel && !penable |-> ##[1:3] indicators.access)
		else $error("access indicator missed");
	detect_lit_a: assert property (aes_in[3].valid |-> ##[1:3] indicators.detect[3])
		else $error("signal detect missed");
endmodule // madi_inserter_monitor
bind madi_channel_group_inserter madi_inserter_monitor i_mon (.pclk, .presetn, .psel, .penable,
	.group_select_switch, .stream_in, .stream_in_locked, .aes_in, .stream_out, .indicators);
`default_nettype wire

//--- madi_stream_source.sv
// Upstream stream and reference model
`timescale 1ns/1ns
`default_nettype none
module madi_stream_source (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        ref_stop,
	output var  logic                        digital_audio_reference,
	output var  logic                        stream_in_locked,
	output var  madi_inserter_pkg::slot_type stream_in
);
	import madi_inserter_pkg::*;
	logic [2:0]  div;
	logic [6:0]  settle;
	logic [23:0] mix;
	// Reference of 8 cycles; slots tied to its phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div <= '0;
			settle <= '0;
			mix <= 24'h5a3c1f;
			stream_in <= '0;
			stream_in_locked <= 1'b0;
		end else begin
			div <= div + 3'd1;
			settle <= settle + {6'd0, settle != 7'h7f};
			// Stop models a lost reference and a lost upstream lock
			stream_in_locked <= settle == 7'h7f && !ref_stop;
			mix <= {mix[22:0], mix[23] ^ mix[18]};
			stream_in.valid <= div[0];
			// Idle cycles carry a changing pattern, never the last sample
			stream_in.sample <= div[0] ? mix : ~stream_in.sample;
			if (stream_in.valid)
				stream_in.channel <= stream_in.channel + 6'd1;
		end
	end
	assign digital_audio_reference = div[2] & ~ref_stop;
endmodule // madi_stream_source
`default_nettype wire

//--- madi_channel_group_inserter_tb.sv
// Self-checking bench for the channel group inserter
`timescale 1ns/1ns
`default_nettype none
module madi_channel_group_inserter_tb;
	import madi_inserter_pkg::*;
	logic                pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]          paddr = '0, sw = 8'hff;
	logic [31:0]         pwdata = '0, prdata, rd, lf = 32'h497b;
	logic                pready, pslverr, irq, ref_clk, locked, err, on = 0, armed = 0;
	logic                ref_stop = 0;
	slot_type            sin, sout;
	subframe_type [11:0] aes = '0;
	indicator_type       ind;
	logic [23:0]         smp [24];
	logic [1:0]          grp [4] = '{2'b11, 2'b00, 2'b01, 2'b10};
	logic [23:0]         q [$];
	int                  mismatches = 0, tests_run = 0;
	always #25 pclk = ~pclk;
	madi_channel_group_inserter #(.ACCESS_HOLD_CYCLES(4)) i_dut (.pclk, .presetn, .paddr, .psel,
		.penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .group_select_switch(sw),
		.digital_audio_reference(ref_clk), .stream_in(sin), .stream_in_locked(locked),
		.aes_in(aes), .stream_out(sout), .indicators(ind), .irq);
	madi_stream_source i_src (.pclk, .presetn, .ref_stop, .digital_audio_reference(ref_clk),
		.stream_in_locked(locked), .stream_in(sin));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [23:0] expect_slot(logic [1:0] g, slot_type s);
		int c;
		c = int'(s.channel) - (g == 2'b01 ? GROUP_MID_BASE : g == 2'b10 ? GROUP_HIGH_BASE : 0);
		if (g == 2'b11)
			return s.sample;
		if (c >= 0 && c < (g == 2'b10 ? GROUP_HIGH_SIZE : GROUP_WIDE_SIZE))
			return smp[c];
		return g == 2'b00 ? 24'h0 : s.sample;
	endfunction
	task automatic check(logic [31:0] seen, logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic apb(logic [7:0] a, logic w, logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			mismatches++;
			complete_run();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge pclk) begin
		armed <= on;
		if (on && sin.valid)
			q.push_back(expect_slot(sw[1:0], sin));
	end
	always @(posedge pclk)
		if (armed && sout.valid && q.size() > 0)
			check(sout.sample, q.pop_front());
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(8'h20, 1'b0, 0);
		check(err, 1);
		check(ind.access, 1);
		apb(ADDR_STATUS, 1'b1, 0);
		check(err, 1);
		apb(ADDR_ENABLE, 1'b1, 32'h8);
		apb(ADDR_ENABLE, 1'b0, 0);
		check(rd, 32'h8);
		foreach (grp[i]) begin
			lf = lfsr(lf);
			sw <= {lf[7:2], grp[i]};
			for (int k = 0; k < 24; k++) begin
				lf = lfsr(lf);
				smp[k] = k < 2 ? 24'h0 : lf[23:0];
			end
			for (int k = 0; k < 12; k++) begin
				@(posedge pclk);
				aes[k] <= '{1'b1, 1'b0, smp[2 * k]};
				@(posedge pclk);
				aes[k] <= '{1'b1, 1'b1, smp[2 * k + 1]};
				@(posedge pclk);
				aes[k] <= '0;
			end
			repeat (8) @(posedge pclk);
			check(ind.detect, 12'hfff);
			on <= 1'b1;
			repeat (140) @(posedge pclk);
			on <= 1'b0;
			repeat (4) @(posedge pclk);
		end
		check(ind.reference, 1);
		check(ind.lock, 1);
		check(irq, 1);
		apb(ADDR_ENABLE, 1'b1, 0);
		repeat (2) @(posedge pclk);
		check(irq, 0);
		apb(ADDR_ENABLE, 1'b1, 32'h8);
		repeat (2) @(posedge pclk);
		check(irq, 1);
		apb(ADDR_CLEAR, 1'b1, 32'h8);
		apb(ADDR_STATUS, 1'b0, 0);
		check(rd[3], 0);
		check(irq, 0);
		// Reference and upstream lock go away; crosspoint inputs already idle
		ref_stop <= 1'b1;
		repeat (AES_TIMEOUT + 200) @(posedge pclk);
		check(ind.reference, 0);
		check(ind.lock, 0);
		check(ind.detect, 0);
		apb(ADDR_STATUS, 1'b0, 0);
		check(rd[EV_REF_LOST], 1);
		check(rd[EV_LOCK_LOST], 1);
		check(irq, 1);
		complete_run();
	end
endmodule // madi_channel_group_inserter_tb
`default_nettype wire
